// ### hdl/wdw_core.sv
// Watchdog timer with keyed control and low-power wake-up sequencing
`timescale 1ns/100ps
`default_nettype none
module wdw_core #(
  parameter int PORTA_W = 8,
  parameter int IRQ_W = 4,
  parameter int FAST_SST_CYC = 16,
  parameter int SLOW_SST_TICKS = 1024
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_rc_pin,
  input wire logic slow_xtal_pin,
  input wire logic [PORTA_W-1:0] porta_pin,
  input wire wdw_pkg::wdw_core_ev_t core_ev,
  input wire logic [IRQ_W-1:0] irq_req,
  input wire logic [IRQ_W-1:0] irq_en,
  input wire logic stack_full,
  output wdw_pkg::wdw_wake_t wake_out,
  output logic core_run,
  output logic fast_osc_on,
  output logic fast_osc_stable_flag,
  output logic sysclk_from_slow_rc,
  output logic slow_clk_run
);
  import wdw_pkg::*;

  // Parameter checks, refused at elaboration (16-bit start-up counter)
  if (PORTA_W < 1 || PORTA_W > 8) begin
    $error("PORTA_W must be 1 to 8");
  end
  if (IRQ_W < 1 || FAST_SST_CYC < 1 || FAST_SST_CYC > 65535) begin
    $error("IRQ_W or FAST_SST_CYC out of range");
  end
  if (SLOW_SST_TICKS < 1 || SLOW_SST_TICKS > 65535) begin
    $error("SLOW_SST_TICKS out of range");
  end

  localparam int PW = PORTA_W + 2;
  localparam logic [15:0] FAST_LAST = 16'(FAST_SST_CYC - 1);
  localparam logic [15:0] SLOW_LAST = 16'(SLOW_SST_TICKS - 1);

  logic [PW-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [7:0] wdctl_q, wake_en_q;
  logic key_flag_q, syskeep_q, expiry_q, pdf_q;
  logic fast_start_enable_q, fxtal_q, sxtal_q;
  logic [1:0] keyc_q;
  logic [CNT_W-1:0] cnt_q;
  logic [IRQ_W-1:0] irq_wmask_q;
  wdw_pstate_t state_q, state_d;
  logic [15:0] sst_q;
  logic fast_stable_q, slow_stable_q, slow_rc_sys_q;
  wdw_wake_t wake_q, pend_q, kind_d;
  logic [31:0] prdata_q;

  // Two-stage synchronisers plus an edge stage on slow clocks and Port A
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else if (ce) begin
      pin_s1_q <= {slow_xtal_pin, slow_rc_pin, porta_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Edge detection and clock selection
  wire rc_tick = pin_s2_q[PORTA_W] & ~pin_s3_q[PORTA_W];
  wire xtal_tick = pin_s2_q[PORTA_W+1] & ~pin_s3_q[PORTA_W+1];
  wire [4:0] key = wdctl_q[KEY_MSB:KEY_LSB];
  wire wd_en = (key == KEY_ENABLE);
  wire key_ok = wd_en | (key == KEY_DISABLE);
  wire slow_tick = wd_en & (sxtal_q ? xtal_tick : rc_tick);
  wire [4:0] per_exp = wdw_period_exp(wdctl_q[PER_MSB:0]);
  wire [CNT_W-1:0] per_mask = ~({CNT_W{1'b1}} << per_exp);
  wire ovf = slow_tick & (cnt_q == per_mask);
  wire key_fire = ~key_ok & rc_tick & (keyc_q == KEY_RST_TICKS - 2'h1);
  wire sleeping = (state_q == PS_IDLE) | (state_q == PS_LSLEEP) |
                  (state_q == PS_DSLEEP);

  // Per-pin wake enables on falling edges
  logic [PORTA_W-1:0] pin_wake;
  genvar gi;
  generate
    for (gi = 0; gi < PORTA_W; gi++) begin : g_pin
      assign pin_wake[gi] = wake_en_q[gi] & pin_s3_q[gi] & ~pin_s2_q[gi];
    end
  endgenerate

  // Wake sources
  wire [IRQ_W-1:0] irq_wake = irq_req & irq_wmask_q;
  wire any_pin = |pin_wake;
  wire any_irq = |irq_wake;
  wire irq_take = |(irq_wake & irq_en) & ~stack_full;
  wire wake_now = sleeping & (ovf | any_pin | any_irq);
  wire fast_start = (state_q == PS_LSLEEP) & fast_start_enable_q & fxtal_q;

  // Kind of wake-up reported to the core
  always_comb begin
    kind_d = '0;
    if (ovf) begin
      kind_d.pc_sp_reset = 1'b1;
    end else if (any_pin) begin
      kind_d.resume_next = 1'b1;
    end else if (irq_take) begin
      kind_d.irq_service = 1'b1;
    end else begin
      kind_d.resume_next = 1'b1;
    end
  end

  // Next power state
  always_comb begin
    state_d = state_q;
    case (state_q)
      PS_RUN: begin
        if (core_ev.halt) begin
          if (core_ev.idle_sel) begin
            state_d = PS_IDLE;
          end else if (wd_en) begin
            state_d = PS_LSLEEP;
          end else begin
            state_d = PS_DSLEEP;
          end
        end
      end
      PS_IDLE, PS_LSLEEP, PS_DSLEEP: begin
        if (wake_now) begin
          state_d = (fast_stable_q | fast_start) ? PS_RUN : PS_FSST;
        end
      end
      PS_FSST: begin
        if (fast_stable_q) begin
          state_d = PS_RUN;
        end
      end
      default: state_d = PS_RUN;
    endcase
  end

  // Fast oscillator runs in run, start-up and idle with clock kept
  assign fast_osc_on = (state_q == PS_RUN) | (state_q == PS_FSST) |
                       ((state_q == PS_IDLE) & syskeep_q);

  // Power state and wake pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= PS_RUN;
      wake_q <= '0;
      pend_q <= '0;
      irq_wmask_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      wake_q <= '0;
      wake_q.sys_reset <= key_fire | (ovf & (state_q == PS_RUN));
      if (core_ev.halt && state_q == PS_RUN) begin
        irq_wmask_q <= ~irq_req;
      end
      if (wake_now && state_d == PS_RUN) begin
        wake_q.resume_next <= kind_d.resume_next;
        wake_q.irq_service <= kind_d.irq_service;
        wake_q.pc_sp_reset <= kind_d.pc_sp_reset;
      end else if (wake_now) begin
        pend_q <= kind_d;
      end else if (state_q == PS_FSST && state_d == PS_RUN) begin
        wake_q.resume_next <= pend_q.resume_next;
        wake_q.irq_service <= pend_q.irq_service;
        wake_q.pc_sp_reset <= pend_q.pc_sp_reset;
      end
    end
  end

  // Shared start-up counter: fast phase in pclk, then slow crystal phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sst_q <= '0;
      fast_stable_q <= 1'b0;
      slow_stable_q <= 1'b0;
      slow_rc_sys_q <= 1'b0;
    end else if (ce) begin
      if (!fast_osc_on) begin
        fast_stable_q <= 1'b0;
        sst_q <= '0;
      end else if (!fast_stable_q) begin
        sst_q <= (sst_q == FAST_LAST) ? 16'h0000 : sst_q + 16'h0001;
        fast_stable_q <= (sst_q == FAST_LAST);
      end else if (sxtal_q && wd_en && !slow_stable_q && xtal_tick) begin
        sst_q <= sst_q + 16'h0001;
        slow_stable_q <= (sst_q == SLOW_LAST);
      end
      if (!wd_en || state_q == PS_DSLEEP) begin
        slow_stable_q <= 1'b0;
      end
      if (wake_now && fast_start && !fast_stable_q) begin
        slow_rc_sys_q <= 1'b1;
      end else if (fast_stable_q) begin
        slow_rc_sys_q <= 1'b0;
      end
    end
  end

  // Key invalid counter in slow RC edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keyc_q <= '0;
    end else if (ce) begin
      if (key_ok || key_fire) begin
        keyc_q <= '0;
      end else if (rc_tick) begin
        keyc_q <= keyc_q + 2'h1;
      end
    end
  end

  // Watchdog counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (key_fire || core_ev.clear_watchdog_instruction || core_ev.halt || ovf) begin
        cnt_q <= '0;
      end else if (slow_tick && state_q != PS_DSLEEP) begin
        cnt_q <= cnt_q + 18'h00001;
      end
    end
  end

  // APB decode
  wire apb_wr = psel & penable & pwrite & pstrb[0] & ce;
  wire hit_wdctl = (paddr == OFS_WDCTL);
  wire hit_flags = (paddr == OFS_FLAGS);
  wire hit_stat = (paddr == OFS_STAT);
  wire hit_wake = (paddr == OFS_WAKE);
  wire hit_osc = (paddr == OFS_OSC);
  wire mapped = hit_wdctl | hit_flags | hit_stat | hit_wake | hit_osc;
  wire [7:0] flags_rd = {syskeep_q, 6'h00, key_flag_q};
  wire [7:0] stat_rd = {3'h0, slow_rc_sys_q, slow_stable_q, fast_stable_q,
                        pdf_q, expiry_q};
  wire [7:0] osc_rd = {5'h00, sxtal_q, fxtal_q, fast_start_enable_q};
  wire [7:0] rd_sel = hit_wdctl ? wdctl_q : hit_flags ? flags_rd :
                      hit_stat ? stat_rd : hit_wake ? wake_en_q :
                      hit_osc ? osc_rd : 8'h00;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Read data latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (ce && psel && !penable) begin
      prdata_q <= {24'h000000, rd_sel};
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdctl_q <= WDCTL_RESET;
      wake_en_q <= '0;
      syskeep_q <= 1'b0;
      fast_start_enable_q <= 1'b0;
      fxtal_q <= 1'b0;
      sxtal_q <= 1'b0;
    end else if (ce) begin
      if (key_fire) begin
        wdctl_q <= WDCTL_RESET;
      end else if (apb_wr && hit_wdctl) begin
        wdctl_q <= pwdata[7:0];
      end
      if (apb_wr && hit_wake) begin
        wake_en_q <= pwdata[7:0];
      end
      if (apb_wr && hit_flags) begin
        syskeep_q <= pwdata[FLG_SYSKEEP];
      end
      if (apb_wr && hit_osc) begin
        fast_start_enable_q <= pwdata[OSC_FAST_START_ENABLE];
        fxtal_q <= pwdata[OSC_FXTAL];
        sxtal_q <= pwdata[OSC_SXTAL];
      end
    end
  end

  // Reset-cause flags; hardware set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_flag_q <= 1'b0;
      expiry_q <= 1'b0;
      pdf_q <= 1'b0;
    end else if (ce) begin
      if (key_fire) begin
        key_flag_q <= 1'b1;
      end else if (apb_wr && hit_flags && !pwdata[FLG_KEY]) begin
        key_flag_q <= 1'b0;
      end
      if (ovf) begin
        expiry_q <= 1'b1;
      end else if (core_ev.halt) begin
        expiry_q <= 1'b0;
      end
      if (core_ev.halt) begin
        pdf_q <= 1'b1;
      end else if (core_ev.clear_watchdog_instruction) begin
        pdf_q <= 1'b0;
      end
    end
  end

  // Outputs
  assign prdata = prdata_q;
  assign wake_out = wake_q;
  assign core_run = (state_q == PS_RUN);
  assign fast_osc_stable_flag = fast_stable_q;
  assign sysclk_from_slow_rc = slow_rc_sys_q;
  assign slow_clk_run = wd_en;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_key_flag;
    ce && key_fire |=> key_flag_q && wdctl_q == WDCTL_RESET;
  endproperty
  a_key_flag: assert property (p_key_flag) else $error("key reset lost");

  property p_key_delay;
    ce && $fell(key_ok) |-> !key_fire [*2];
  endproperty
  a_key_delay: assert property (p_key_delay) else $error("key reset early");

  property p_run_ovf;
    ce && ovf && core_run |=> wake_out.sys_reset && expiry_q && cnt_q == '0;
  endproperty
  a_run_ovf: assert property (p_run_ovf) else $error("run overflow wrong");

  property p_sleep_ovf;
    ce && ovf && sleeping |=> expiry_q && pdf_q && !wake_out.sys_reset;
  endproperty
  a_sleep_ovf: assert property (p_sleep_ovf) else $error("sleep ovf flags");

  property p_halt_flags;
    ce && core_ev.halt && !ovf |=> pdf_q && !expiry_q && cnt_q == '0;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags");

  property p_clr;
    ce && core_ev.clear_watchdog_instruction && !core_ev.halt |=> !pdf_q && cnt_q == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear instr failed");

  sequence s_from_fsst;
    state_q == PS_FSST ##1 core_run;
  endsequence
  property p_fsst;
    s_from_fsst |-> fast_stable_q;
  endproperty
  a_fsst: assert property (p_fsst) else $error("ran before stable");

  property p_pin_wake;
    ce && sleeping && any_pin |=> core_run || state_q == PS_FSST;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake lost");
endmodule
`default_nettype wire

// ### common/wdw_pkg.sv
// Constants, types and register map of the watchdog and wake-up block
package wdw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_WDCTL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_WAKE = 8'h0C;
  localparam logic [7:0] OFS_OSC = 8'h10;
  // watchdog_control layout and values
  localparam logic [7:0] WDCTL_RESET = 8'h53;
  localparam int KEY_LSB = 3;
  localparam int KEY_MSB = 7;
  localparam int PER_MSB = 2;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [4:0] KEY_ENABLE = 5'h0A;
  // system_reset_flags bit positions
  localparam int FLG_KEY = 0;
  localparam int FLG_SYSKEEP = 7;
  // Status register bit positions
  localparam int ST_EXPIRY = 0;
  localparam int ST_PDF = 1;
  localparam int ST_FAST = 2;
  localparam int ST_SLOW = 3;
  localparam int ST_SLOWRC = 4;
  // Oscillator configuration bit positions
  localparam int OSC_FAST_START_ENABLE = 0;
  localparam int OSC_FXTAL = 1;
  localparam int OSC_SXTAL = 2;
  // Counter width and key-reset delay in slow RC edges
  localparam int CNT_W = 18;
  localparam logic [1:0] KEY_RST_TICKS = 2'h2;
  // Power states, one-hot
  typedef enum logic [4:0] {
    PS_RUN = 5'h01,
    PS_IDLE = 5'h02,
    PS_LSLEEP = 5'h04,
    PS_DSLEEP = 5'h08,
    PS_FSST = 5'h10
  } wdw_pstate_t;
  // Pulses from the processor core
  typedef struct packed {
    logic halt;
    logic clear_watchdog_instruction;
    logic idle_sel;
  } wdw_core_ev_t;
  // Pulses back to the processor core
  typedef struct packed {
    logic resume_next;
    logic irq_service;
    logic pc_sp_reset;
    logic sys_reset;
  } wdw_wake_t;
  // Period code to exponent: 8,10,12,14,15,16,17,18
  function automatic logic [4:0] wdw_period_exp(input logic [2:0] code);
    logic [4:0] e;
    e = 5'h08;
    case (code)
      3'h0: e = 5'h08;
      3'h1: e = 5'h0A;
      3'h2: e = 5'h0C;
      3'h3: e = 5'h0E;
      3'h4: e = 5'h0F;
      3'h5: e = 5'h10;
      3'h6: e = 5'h11;
      default: e = 5'h12;
    endcase
    return e;
  endfunction
endpackage

// ### testbench/wdw_core_test.sv
// Self-checking testbench of the watchdog and wake-up block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t got %0h want %0h", $time, a, b); end end
module wdw_core_test;
  import wdw_pkg::*;
  localparam logic [3:0] W_RES = 4'h8;
  localparam logic [3:0] W_IRQ = 4'h4;
  localparam logic [3:0] W_PCSP = 4'h2;
  localparam logic [3:0] W_SYS = 4'h1;
  localparam int EXPO [8] = '{8, 10, 12, 14, 15, 16, 17, 18};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic slow_rc_pin = 1'b0;
  logic tgl = 1'b0;
  logic slow_xtal_pin = 1'b0;
  logic [1:0] xdiv = 2'h0;
  logic ce = 1'b1;
  logic [3:0] pstrb = 4'hF;
  int xtal_edges = 0;
  logic [7:0] porta_pin = 8'hFF;
  wdw_core_ev_t core_ev = '0;
  logic [3:0] irq_req = 4'h0;
  logic [3:0] irq_en = 4'h0;
  logic stack_full = 1'b0;
  wdw_wake_t wake_out;
  logic [3:0] wk;
  logic core_run, fast_osc_on, fast_osc_stable_flag;
  logic sysclk_from_slow_rc, slow_clk_run;
  int n_errors = 0;
  int check_count = 0;
  int slow_edges = 0;
  assign wk = wake_out;
  // Bus clock, free-running slow RC of four and crystal of eight cycles
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    tgl <= ~tgl;
    xdiv <= xdiv + 2'h1;
    if (tgl) begin
      slow_rc_pin <= ~slow_rc_pin;
      if (!slow_rc_pin) slow_edges <= slow_edges + 1;
    end
    if (xdiv == 2'h3) begin
      slow_xtal_pin <= ~slow_xtal_pin;
      if (!slow_xtal_pin) xtal_edges <= xtal_edges + 1;
    end
  end
  wdw_core #(.PORTA_W(8), .IRQ_W(4), .FAST_SST_CYC(4), .SLOW_SST_TICKS(8))
  dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_rc_pin(slow_rc_pin), .slow_xtal_pin(slow_xtal_pin),
    .porta_pin(porta_pin),
    .core_ev(core_ev), .irq_req(irq_req), .irq_en(irq_en),
    .stack_full(stack_full), .wake_out(wake_out), .core_run(core_run),
    .fast_osc_on(fast_osc_on), .fast_osc_stable_flag(fast_osc_stable_flag),
    .sysclk_from_slow_rc(sysclk_from_slow_rc), .slow_clk_run(slow_clk_run));
  // Verdict and end of run
  task summarize;
    begin
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task timeout;
    begin
      n_errors++;
      $display("BAD %0t wait ran out", $time);
      summarize();
    end
  endtask
  // One APB transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [31:0] r, output logic e);
    int i;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      i = 0;
      while (pready !== 1'b1 && i < 20) begin
        @(posedge pclk);
        i++;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) timeout();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 8'h00, r, e);
  endtask
  // One-cycle pulse on the core event lines
  task ev(input logic h, input logic c, input logic i);
    @(posedge pclk);
    core_ev <= '{halt: h, clear_watchdog_instruction: c, idle_sel: i};
    @(posedge pclk);
    core_ev <= '0;
  endtask
  // Wait for a wake pulse and judge its kind
  task wait_wk(input logic [3:0] exp, input int bound, output int n);
    for (n = 0; n < bound; n++) begin
      @(negedge pclk);
      if (wk !== 4'h0) break;
    end
    if (n == bound) timeout();
    `CHK(wk, exp)
    @(posedge pclk);
  endtask
  task quiet(input int cyc);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(negedge pclk);
      if (wk !== 4'h0) bad++;
    end
    `CHK(bad, 0)
    @(posedge pclk);
  endtask
  // Reset values, unmapped access, read-only status
  task t_reset;
    logic [31:0] r;
    logic e;
    rd(OFS_WDCTL, r);
    `CHK(r, 32'h53)
    rd(OFS_FLAGS, r);
    `CHK(r, 32'h0)
    wr(OFS_STAT, 8'hFF);
    rd(OFS_STAT, r);
    `CHK(r[1:0], 2'b00)
    apb(1'b0, 8'h14, 8'h00, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
    `CHK({core_run, slow_clk_run}, 2'b11)
    `CHK(pready, 1'b1)
  endtask
  // Overflow length per period code, with a clear part way through
  task t_period(input logic [2:0] code);
    int e0, n, len;
    logic [31:0] r;
    len = 1 << EXPO[code];
    wr(OFS_WDCTL, {KEY_ENABLE, code});
    ev(1'b0, 1'b1, 1'b0);
    repeat (800) @(posedge pclk);
    ev(1'b0, 1'b1, 1'b0);
    e0 = slow_edges;
    wait_wk(W_SYS, 4 * len + 64, n);
    n = slow_edges - e0;
    `CHK(n >= len - 1 && n <= len + 2, 1'b1)
    rd(OFS_STAT, r);
    `CHK(r[ST_EXPIRY], 1'b1)
  endtask
  // Overflow length on the slow crystal, and its start-up count
  task t_xtal;
    int e0, n;
    logic [31:0] r;
    wr(OFS_OSC, 8'h04);
    wr(OFS_WDCTL, {KEY_ENABLE, 3'h0});
    ev(1'b0, 1'b1, 1'b0);
    e0 = xtal_edges;
    wait_wk(W_SYS, 2400, n);
    n = xtal_edges - e0;
    `CHK(n >= 255 && n <= 258, 1'b1)
    rd(OFS_STAT, r);
    `CHK({r[ST_SLOW], r[ST_EXPIRY]}, 2'b11)
    wr(OFS_OSC, 8'h00);
  endtask
  // Disable key, then an invalid key and the flag it leaves
  task t_keys;
    int n;
    logic [31:0] r;
    wr(OFS_WDCTL, {KEY_DISABLE, 3'h0});
    ev(1'b0, 1'b1, 1'b0);
    `CHK(slow_clk_run, 1'b0)
    quiet(1300);
    wr(OFS_WDCTL, 8'h03);
    wait_wk(W_SYS, 30, n);
    `CHK(n >= 4 && n <= 16, 1'b1)
    rd(OFS_FLAGS, r);
    `CHK(r[FLG_KEY], 1'b1)
    rd(OFS_WDCTL, r);
    `CHK(r, 32'h53)
    wr(OFS_FLAGS, 8'h01);
    rd(OFS_FLAGS, r);
    `CHK(r[FLG_KEY], 1'b1)
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, r);
    `CHK(r[FLG_KEY], 1'b0)
  endtask
  // Writes with the byte strobe or the clock enable low are lost
  task t_gate;
    logic [31:0] r;
    pstrb <= 4'h0;
    wr(OFS_WAKE, 8'h5A);
    pstrb <= 4'hF;
    ce <= 1'b0;
    wr(OFS_WAKE, 8'hA5);
    ce <= 1'b1;
    rd(OFS_WAKE, r);
    `CHK(r, 32'h0)
  endtask
  // Idle with clock kept: pin wake and interrupt wakes
  task t_idle;
    int n;
    logic [31:0] r;
    wr(OFS_FLAGS, 8'h80);
    wr(OFS_WAKE, 8'h01);
    wr(OFS_WDCTL, {KEY_ENABLE, 3'h7});
    ev(1'b1, 1'b0, 1'b1);
    @(negedge pclk);
    `CHK(core_run, 1'b0)
    rd(OFS_STAT, r);
    `CHK(r[1:0], 2'b10)
    porta_pin <= 8'hFD;
    quiet(12);
    porta_pin <= 8'hFC;
    wait_wk(W_RES, 20, n);
    porta_pin <= 8'hFF;
    ev(1'b0, 1'b1, 1'b0);
    rd(OFS_STAT, r);
    `CHK(r[ST_PDF], 1'b0)
    irq_req <= 4'h1;
    ev(1'b1, 1'b0, 1'b1);
    quiet(12);
    irq_en <= 4'h2;
    irq_req <= 4'h3;
    wait_wk(W_IRQ, 20, n);
    irq_req <= 4'h0;
    ev(1'b1, 1'b0, 1'b1);
    irq_en <= 4'h0;
    irq_req <= 4'h4;
    wait_wk(W_RES, 20, n);
    irq_req <= 4'h0;
    stack_full <= 1'b1;
    irq_en <= 4'hF;
    ev(1'b1, 1'b0, 1'b1);
    irq_req <= 4'h8;
    wait_wk(W_RES, 20, n);
    irq_req <= 4'h0;
    stack_full <= 1'b0;
  endtask
  // Light sleep overflow, deep sleep start-up, fast start
  task t_sleep;
    int e0, n;
    logic [31:0] r;
    wr(OFS_FLAGS, 8'h00);
    wr(OFS_WDCTL, {KEY_ENABLE, 3'h0});
    ev(1'b1, 1'b0, 1'b0);
    e0 = slow_edges;
    wait_wk(W_PCSP, 1400, n);
    `CHK(slow_edges - e0 >= 255, 1'b1)
    rd(OFS_STAT, r);
    `CHK(r[1:0], 2'b11)
    wr(OFS_WDCTL, {KEY_DISABLE, 3'h0});
    ev(1'b1, 1'b0, 1'b0);
    @(negedge pclk);
    `CHK(fast_osc_on, 1'b0)
    @(posedge pclk);
    porta_pin <= 8'hFE;
    wait_wk(W_RES, 40, n);
    `CHK({n >= 4, fast_osc_stable_flag}, 2'b11)
    porta_pin <= 8'hFF;
    wr(OFS_OSC, 8'h03);
    wr(OFS_WDCTL, {KEY_ENABLE, 3'h7});
    ev(1'b1, 1'b0, 1'b0);
    porta_pin <= 8'hFE;
    wait_wk(W_RES, 40, n);
    @(negedge pclk);
    `CHK(sysclk_from_slow_rc, 1'b1)
    @(posedge pclk);
    porta_pin <= 8'hFF;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    for (int c = 0; c < 3; c++) t_period(3'(c));
    t_xtal();
    t_keys();
    t_gate();
    t_idle();
    t_sleep();
    summarize();
  end
endmodule
`default_nettype wire
